// *** rtl/nrps_defs.svh ***
// Command bytes, timing counts and sizes for the flash command sequencer
`ifndef NRPS_DEFS_SVH
`define NRPS_DEFS_SVH
`define NRPS_CLK_NS        20
`define NRPS_T_STROBE_NS   40
`define NRPS_TICK_CYC      ((`NRPS_T_STROBE_NS + `NRPS_CLK_NS - 1) / `NRPS_CLK_NS)
`define NRPS_T_WB_NS       100
`define NRPS_WB_CYC        ((`NRPS_T_WB_NS + `NRPS_CLK_NS - 1) / `NRPS_CLK_NS)
`define NRPS_CMD_READ      8'h00
`define NRPS_CMD_READ_GO   8'h30
`define NRPS_CMD_COL_OUT   8'h05
`define NRPS_CMD_COL_GO    8'he0
`define NRPS_CMD_CACHE     8'h31
`define NRPS_CMD_CACHE_END 8'h3f
`define NRPS_CMD_MREAD_SET 8'h60
`define NRPS_CMD_PROG      8'h80
`define NRPS_CMD_PROG_MP2  8'h81
`define NRPS_CMD_PROG_MP1  8'h11
`define NRPS_CMD_PROG_GO   8'h10
`define NRPS_CMD_COL_IN    8'h85
`define NRPS_CMD_STATUS    8'h70
`define NRPS_CMD_RESET     8'hff
`define NRPS_LAST_PAGE     6'h3f
`define NRPS_FIFO_DEPTH    8
`define NRPS_FIFO_WIDTH    8
`endif

// *** rtl/nrps_pkg.sv ***
// Types shared by the flash command sequencer
package nrps_pkg;
	typedef enum logic [3:0] {
		NRPS_OP_READ = 4'h0, NRPS_OP_READ_COL = 4'h1, NRPS_OP_CNEXT = 4'h2,
		NRPS_OP_CLAST = 4'h3, NRPS_OP_MREAD = 4'h4, NRPS_OP_PROG = 4'h5,
		NRPS_OP_MPROG = 4'h6, NRPS_OP_STATUS = 4'h7, NRPS_OP_RESET = 4'h8
	} nrps_op_e;
	typedef enum logic [3:0] {
		K_CMD = 4'h0, K_A5 = 4'h1, K_A3 = 4'h2, K_A2 = 4'h3, K_WR = 4'h4,
		K_RD = 4'h5, K_WAIT = 4'h6, K_STAT = 4'h7, K_END = 4'h8
	} nrps_kind_e;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0, ST_FETCH = 3'h1, ST_LOW = 3'h2, ST_HIGH = 3'h3,
		ST_WB = 3'h4, ST_BUSY = 3'h5
	} nrps_state_e;
	typedef struct packed {
		nrps_kind_e  kind;
		logic        sel;
		logic [7:0]  val;
	} nrps_step_s;
	typedef struct packed {
		nrps_op_e    op;
		logic [11:0] col;
		logic [16:0] row;
		logic [16:0] row2;
		logic [11:0] col2;
		logic [11:0] cnt;
		logic [11:0] cnt2;
	} nrps_req_s;
	typedef struct packed {
		logic        cle;
		logic        ale;
		logic        ce_n;
		logic        we_n;
		logic        read_strobe_n;
		logic        wp_n;
		logic [7:0]  io;
		logic        oe;
	} nrps_pins_s;
endpackage

// *** rtl/nrps_pace.sv ***
// Strobe pacing divider: one-cycle tick per strobe phase
`timescale 1ns/100ps
`include "nrps_defs.svh"
module nrps_pace (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic run,
	output logic      tick
);
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;

	// Restarts whenever idle so every phase is a full period long
	always_comb begin
		tick = run && (cnt_q == 4'(`NRPS_TICK_CYC - 1));
		cnt_d = cnt_q;
		if (!run || tick) begin
			cnt_d = 4'h0;
		end else begin
			cnt_d = 4'(cnt_q + 4'h1);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_q <= 4'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule // nrps_pace

// *** rtl/nrps_fifo.sv ***
// Program data FIFO with registered full and empty flags
`timescale 1ns/100ps
module nrps_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem [D];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [AW:0]   cnt_q, cnt_d;
	logic          full_q, full_d, empty_q, empty_d, push, pop, room_q;

	// Flags registered so the ready seen by the writer is a flop
	always_comb begin
		push = in_valid && !full_q;
		pop = out_ready && !empty_q;
		wp_d = push ? AW'((wp_q + 1) % D) : wp_q;
		rp_d = pop ? AW'((rp_q + 1) % D) : rp_q;
		cnt_d = (AW+1)'(cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
		full_d = (cnt_d == (AW+1)'(D));
		empty_d = (cnt_d == '0);
	end

	assign in_ready = room_q; // Own flop so the writer sees no gate after it
	assign out_valid = !empty_q;
	assign out_data = mem[rp_q];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_q] <= in_data;
		end
		if (srst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			full_q <= 1'b0;
			room_q <= 1'b1;
			empty_q <= 1'b1;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
			full_q <= full_d;
			room_q <= !full_d;
			empty_q <= empty_d;
		end
	end
endmodule // nrps_fifo

// *** rtl/nrps_top.sv ***
// Host-side command sequencer driving a byte-wide flash over its pins
// What this block does
// - Page read is 00h, address, then 30h
// - Restart cached read when block changes
// - Multi read: 60h addr, 60h addr, 30h
// - Both districts use same page bits
// - One block per district, any order
// - Keep write protect high during multi read
// - Restart multi read cache on block change
// - Only status or reset between 11h, 81h
`timescale 1ns/100ps
`include "nrps_defs.svh"
module nrps_top
	import nrps_pkg::*;
(
	input  wire logic       CLK,
	input  wire logic       SRST,
	input  wire logic       REQ_VALID,
	input  wire nrps_req_s  REQ,
	output logic            REQ_READY,
	output logic            DONE,
	output logic            ERR,
	input  wire logic       WR_VALID,
	input  wire logic [7:0] WR_DATA,
	output logic            WR_READY,
	output logic            RD_VALID,
	output logic [7:0]      RD_DATA,
	output logic            STAT_FAIL,
	input  wire logic       PROTECT,
	input  wire logic [7:0] IO_IN,
	input  wire logic       RB_N,
	output nrps_pins_s      PINS
);
	nrps_state_e st_q, st_d;
	nrps_req_s   req_q, req_d;
	nrps_pins_s  pins_q, pins_d;
	nrps_step_s  step;
	logic [3:0]  idx_q, idx_d;
	logic [11:0] sub_q, sub_d, lim;
	logic [3:0]  wbc_q, wbc_d;
	logic [16:0] crow_q, crow_d;
	logic        cok_q, cok_d, rdy_q, rdy_d, done_q, done_d, err_q, err_d;
	logic        rdv_q, rdv_d, fail_q, fail_d, tick, pop, f_valid, rd_kind;
	logic [7:0]  rdd_q, rdd_d, lc_q, lc_d, pc_q, pc_d, f_data;

	// One table walks every operation; sel picks the second address or count
	function automatic nrps_step_s seq_step(nrps_op_e op, logic [3:0] i);
		nrps_step_s s;
		s = '{K_END, 1'b0, 8'h00};
		case (op)
			NRPS_OP_READ: case (i)
				4'h0: s = '{K_CMD, 1'b0, `NRPS_CMD_READ};
				4'h1: s = '{K_A5, 1'b0, 8'h00};
				4'h2: s = '{K_CMD, 1'b0, `NRPS_CMD_READ_GO};
				4'h3: s = '{K_WAIT, 1'b0, 8'h00};
				4'h4: s = '{K_RD, 1'b0, 8'h00};
				default: s = '{K_END, 1'b0, 8'h00};
			endcase
			NRPS_OP_READ_COL: case (i)
				4'h0: s = '{K_CMD, 1'b0, `NRPS_CMD_COL_OUT};
				4'h1: s = '{K_A2, 1'b0, 8'h00};
				4'h2: s = '{K_CMD, 1'b0, `NRPS_CMD_COL_GO};
				4'h3: s = '{K_RD, 1'b0, 8'h00};
				default: s = '{K_END, 1'b0, 8'h00};
			endcase
			NRPS_OP_CNEXT, NRPS_OP_CLAST: case (i)
				4'h0: s = '{K_CMD, 1'b0, (op == NRPS_OP_CNEXT) ?
					`NRPS_CMD_CACHE : `NRPS_CMD_CACHE_END};
				4'h1: s = '{K_WAIT, 1'b0, 8'h00};
				4'h2: s = '{K_RD, 1'b0, 8'h00};
				default: s = '{K_END, 1'b0, 8'h00};
			endcase
			NRPS_OP_MREAD: case (i)
				4'h0: s = '{K_CMD, 1'b0, `NRPS_CMD_MREAD_SET};
				4'h1: s = '{K_A3, 1'b0, 8'h00};
				4'h2: s = '{K_CMD, 1'b0, `NRPS_CMD_MREAD_SET};
				4'h3: s = '{K_A3, 1'b1, 8'h00};
				4'h4: s = '{K_CMD, 1'b0, `NRPS_CMD_READ_GO};
				4'h5: s = '{K_WAIT, 1'b0, 8'h00};
				default: s = '{K_END, 1'b0, 8'h00};
			endcase
			NRPS_OP_PROG: case (i)
				4'h0: s = '{K_CMD, 1'b0, `NRPS_CMD_PROG};
				4'h1: s = '{K_A5, 1'b0, 8'h00};
				4'h2: s = '{K_WR, 1'b0, 8'h00};
				4'h3: s = '{K_CMD, 1'b0, `NRPS_CMD_COL_IN};
				4'h4: s = '{K_A2, 1'b1, 8'h00};
				4'h5: s = '{K_WR, 1'b1, 8'h00};
				4'h6: s = '{K_CMD, 1'b0, `NRPS_CMD_PROG_GO};
				4'h7: s = '{K_WAIT, 1'b0, 8'h00};
				4'h8: s = '{K_CMD, 1'b0, `NRPS_CMD_STATUS};
				4'h9: s = '{K_STAT, 1'b0, 8'h00};
				default: s = '{K_END, 1'b0, 8'h00};
			endcase
			NRPS_OP_MPROG: case (i)
				4'h0: s = '{K_CMD, 1'b0, `NRPS_CMD_PROG};
				4'h1: s = '{K_A5, 1'b0, 8'h00};
				4'h2: s = '{K_WR, 1'b0, 8'h00};
				4'h3: s = '{K_CMD, 1'b0, `NRPS_CMD_PROG_MP1};
				4'h4: s = '{K_WAIT, 1'b0, 8'h00};
				4'h5: s = '{K_CMD, 1'b0, `NRPS_CMD_PROG_MP2};
				4'h6: s = '{K_A5, 1'b1, 8'h00};
				4'h7: s = '{K_WR, 1'b0, 8'h00};
				4'h8: s = '{K_CMD, 1'b0, `NRPS_CMD_PROG_GO};
				4'h9: s = '{K_WAIT, 1'b0, 8'h00};
				4'ha: s = '{K_CMD, 1'b0, `NRPS_CMD_STATUS};
				4'hb: s = '{K_STAT, 1'b0, 8'h00};
				default: s = '{K_END, 1'b0, 8'h00};
			endcase
			NRPS_OP_STATUS: case (i)
				4'h0: s = '{K_CMD, 1'b0, `NRPS_CMD_STATUS};
				4'h1: s = '{K_STAT, 1'b0, 8'h00};
				default: s = '{K_END, 1'b0, 8'h00};
			endcase
			NRPS_OP_RESET: case (i)
				4'h0: s = '{K_CMD, 1'b0, `NRPS_CMD_RESET};
				4'h1: s = '{K_WAIT, 1'b0, 8'h00};
				default: s = '{K_END, 1'b0, 8'h00};
			endcase
			default: s = '{K_END, 1'b0, 8'h00};
		endcase
		return s;
	endfunction

	// Address byte k of five: column low, column high, then three row bytes
	function automatic logic [7:0] addr_byte(logic [11:0] c, logic [16:0] r, logic [2:0] k);
		case (k)
			3'h0: return c[7:0];
			3'h1: return {4'h0, c[11:8]};
			3'h2: return r[7:0];
			3'h3: return r[15:8];
			default: return {7'h00, r[16]};
		endcase
	endfunction

	// Refuses sequences the far side must never see
	function automatic logic req_legal(nrps_req_s r, logic cok, logic [16:0] crow);
		case (r.op)
			NRPS_OP_MREAD, NRPS_OP_MPROG:
				return (r.row[5:0] == r.row2[5:0]) && (r.row[6] != r.row2[6]);
			NRPS_OP_CNEXT: return cok && (crow[5:0] != `NRPS_LAST_PAGE);
			NRPS_OP_CLAST: return cok;
			default: return 1'b1;
		endcase
	endfunction

	nrps_pace u_pace (
		.clk  (CLK),
		.srst (SRST),
		.run  ((st_q == ST_LOW) || (st_q == ST_HIGH)),
		.tick (tick)
	);

	nrps_fifo #(.W(`NRPS_FIFO_WIDTH), .D(`NRPS_FIFO_DEPTH)) u_fifo (
		.clk       (CLK),
		.srst      (SRST),
		.in_valid  (WR_VALID),
		.in_ready  (WR_READY),
		.in_data   (WR_DATA),
		.out_valid (f_valid),
		.out_ready (pop),
		.out_data  (f_data)
	);

	// Current step and its byte count
	always_comb begin
		step = seq_step(req_q.op, idx_q);
		rd_kind = (step.kind == K_RD) || (step.kind == K_STAT);
		case (step.kind)
			K_A5: lim = 12'h005;
			K_A3: lim = 12'h003;
			K_A2: lim = 12'h002;
			K_WR: lim = step.sel ? req_q.cnt2 : req_q.cnt;
			K_RD: lim = req_q.cnt;
			default: lim = 12'h001;
		endcase
	end

	// Sequencer next state; strobe phases advance only on pace ticks
	always_comb begin
		st_d = st_q;
		req_d = req_q;
		idx_d = idx_q;
		sub_d = sub_q;
		pins_d = pins_q;
		wbc_d = wbc_q;
		cok_d = cok_q;
		crow_d = crow_q;
		rdy_d = rdy_q;
		rdv_d = 1'b0;
		rdd_d = rdd_q;
		fail_d = fail_q;
		done_d = 1'b0;
		err_d = 1'b0;
		lc_d = lc_q;
		pc_d = pc_q;
		pop = 1'b0;
		pins_d.wp_n = !PROTECT || (st_q != ST_IDLE && req_q.op == NRPS_OP_MREAD);
		case (st_q)
			ST_IDLE: begin
				if (REQ_VALID && rdy_q) begin
					req_d = REQ;
					if (!req_legal(REQ, cok_q, crow_q)) begin
						err_d = 1'b1;
						done_d = 1'b1;
					end else begin
						rdy_d = 1'b0;
						st_d = ST_FETCH;
						idx_d = 4'h0;
						sub_d = 12'h000;
						pins_d.ce_n = 1'b0;
						// Cache chain survives only a plain advance in the same block, a column read or a status read
						case (REQ.op)
							NRPS_OP_READ: begin
								cok_d = 1'b1;
								crow_d = REQ.row;
							end
							NRPS_OP_CNEXT: crow_d = 17'(crow_q + 17'h00001);
							NRPS_OP_READ_COL, NRPS_OP_STATUS: cok_d = cok_q;
							default: cok_d = 1'b0;
						endcase
					end
				end
			end
			ST_FETCH: begin
				pins_d.cle = 1'b0;
				pins_d.ale = 1'b0;
				pins_d.oe = 1'b0;
				case (step.kind)
					K_END: begin
						st_d = ST_IDLE;
						done_d = 1'b1;
						rdy_d = 1'b1;
						pins_d.ce_n = 1'b1;
					end
					K_WAIT: begin
						st_d = ST_WB;
						wbc_d = 4'h0;
					end
					K_WR, K_RD: begin
						if (lim == 12'h000) begin
							idx_d = 4'(idx_q + 4'h1);
						end else begin
							st_d = ST_LOW;
						end
					end
					K_CMD: begin
						// Column change skipped when no second stretch of data
						if (step.val == `NRPS_CMD_COL_IN && req_q.cnt2 == 12'h000) begin
							idx_d = 4'(idx_q + 4'h3);
						end else begin
							st_d = ST_LOW;
						end
					end
					default: st_d = ST_LOW;
				endcase
			end
			ST_LOW: begin
				// Stalls here while the FIFO has no data, strobe kept high
				if (tick && (step.kind != K_WR || f_valid)) begin
					st_d = ST_HIGH;
					pins_d.cle = (step.kind == K_CMD);
					pins_d.ale = (step.kind == K_A5) || (step.kind == K_A3) ||
						(step.kind == K_A2);
					if (rd_kind) begin
						pins_d.read_strobe_n = 1'b0;
					end else begin
						pins_d.we_n = 1'b0;
						pins_d.oe = 1'b1;
						case (step.kind)
							K_CMD: pins_d.io = step.val;
							K_WR: pins_d.io = f_data;
							K_A3: pins_d.io = addr_byte(req_q.col,
								step.sel ? req_q.row2 : req_q.row, 3'(sub_q + 12'h002));
							default: pins_d.io = addr_byte(step.sel ? req_q.col2 : req_q.col,
								step.sel ? req_q.row2 : req_q.row, sub_q[2:0]);
						endcase
						pop = (step.kind == K_WR);
					end
				end
			end
			ST_HIGH: begin
				if (tick) begin
					pins_d.we_n = 1'b1;
					pins_d.read_strobe_n = 1'b1;
					if (rd_kind) begin
						rdd_d = IO_IN;
						rdv_d = 1'b1;
					end
					if (step.kind == K_STAT) begin
						fail_d = IO_IN[0];
					end
					if (step.kind == K_CMD) begin
						pc_d = lc_q;
						lc_d = step.val;
					end
					if (12'(sub_q + 12'h001) == lim) begin
						sub_d = 12'h000;
						idx_d = 4'(idx_q + 4'h1);
						st_d = ST_FETCH;
					end else begin
						sub_d = 12'(sub_q + 12'h001);
						st_d = ST_LOW;
					end
				end
			end
			ST_WB: begin
				// Busy may lag the confirm edge; ignore it until then
				if (wbc_q == 4'(`NRPS_WB_CYC - 1)) begin
					st_d = ST_BUSY;
				end else begin
					wbc_d = 4'(wbc_q + 4'h1);
				end
			end
			ST_BUSY: begin
				if (RB_N) begin
					idx_d = 4'(idx_q + 4'h1);
					st_d = ST_FETCH;
				end
			end
			default: st_d = ST_IDLE;
		endcase
	end

	// State registers; pins park deselected and protected
	always_ff @(posedge CLK) begin
		if (SRST) begin
			st_q <= ST_IDLE;
			req_q <= '0;
			idx_q <= 4'h0;
			sub_q <= 12'h000;
			pins_q <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 8'h00, 1'b0};
			wbc_q <= 4'h0;
			cok_q <= 1'b0;
			crow_q <= 17'h00000;
			rdy_q <= 1'b1;
			rdv_q <= 1'b0;
			rdd_q <= 8'h00;
			fail_q <= 1'b0;
			done_q <= 1'b0;
			err_q <= 1'b0;
			lc_q <= 8'h00;
			pc_q <= 8'h00;
		end else begin
			st_q <= st_d;
			req_q <= req_d;
			idx_q <= idx_d;
			sub_q <= sub_d;
			pins_q <= pins_d;
			wbc_q <= wbc_d;
			cok_q <= cok_d;
			crow_q <= crow_d;
			rdy_q <= rdy_d;
			rdv_q <= rdv_d;
			rdd_q <= rdd_d;
			fail_q <= fail_d;
			done_q <= done_d;
			err_q <= err_d;
			lc_q <= lc_d;
			pc_q <= pc_d;
		end
	end

	assign PINS = pins_q;
	assign REQ_READY = rdy_q;
	assign DONE = done_q;
	assign ERR = err_q;
	assign RD_VALID = rdv_q;
	assign RD_DATA = rdd_q;
	assign STAT_FAIL = fail_q;

	// Checks on what goes out over the pins
	logic cmd_ev, start;
	assign cmd_ev = (st_q == ST_HIGH) && tick && (step.kind == K_CMD);
	assign start = (st_q == ST_FETCH) && (idx_q == 4'h0) && (sub_q == 12'h000);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);

	sequence s_we_pulse;
		!pins_q.we_n [*2] ##1 pins_q.we_n;
	endsequence
	sequence s_quiet;
		pins_q.we_n && pins_q.read_strobe_n;
	endsequence

	chk_read_confirm: assert property (cmd_ev && step.val == `NRPS_CMD_READ_GO |->
		lc_q == `NRPS_CMD_READ || lc_q == `NRPS_CMD_MREAD_SET)
		else $error("read confirm without read setup");
	chk_mread_pair: assert property (cmd_ev && step.val == `NRPS_CMD_READ_GO &&
		lc_q == `NRPS_CMD_MREAD_SET |-> pc_q == `NRPS_CMD_MREAD_SET)
		else $error("multi read confirm after one setup");
	chk_mprog_order: assert property (cmd_ev && step.val == `NRPS_CMD_PROG_MP2 |->
		lc_q == `NRPS_CMD_PROG_MP1)
		else $error("second district setup not after first program");
	chk_wp_held: assert property (st_q == ST_BUSY && req_q.op == NRPS_OP_MREAD |->
		pins_q.wp_n)
		else $error("write protect low during multi read");
	chk_page_match: assert property (start && $past(st_q) == ST_IDLE &&
		(req_q.op == NRPS_OP_MREAD || req_q.op == NRPS_OP_MPROG) |->
		req_q.row[5:0] == req_q.row2[5:0])
		else $error("district page bits differ");
	chk_one_per_dist: assert property (start && $past(st_q) == ST_IDLE &&
		(req_q.op == NRPS_OP_MREAD || req_q.op == NRPS_OP_MPROG) |->
		req_q.row[6] != req_q.row2[6])
		else $error("two blocks in one district");
	chk_cache_block: assert property (start && $past(st_q) == ST_IDLE &&
		req_q.op == NRPS_OP_CNEXT |-> $past(cok_q) && $past(crow_q[5:0]) != `NRPS_LAST_PAGE)
		else $error("cached read crosses block");
	chk_mread_chain: assert property (start && req_q.op == NRPS_OP_MREAD |-> !cok_q)
		else $error("cache chain kept over multi read");
	chk_we_width: assert property ($fell(pins_q.we_n) |-> s_we_pulse)
		else $error("write strobe low time wrong");
	chk_busy_quiet: assert property (st_q == ST_BUSY && !RB_N |=> s_quiet)
		else $error("strobe while device busy");
endmodule // nrps_top

// *** verif/nrps_flash_model.sv ***
// Behavioural flash device answering the sequencer's pins
`timescale 1ns/100ps
module nrps_flash_model
	import nrps_pkg::*;
#(
	parameter int BUSY_CYC = 20
) (
	input  wire logic       clk,
	input  wire nrps_pins_s pins,
	input  wire logic       fail_in,
	output logic [7:0]      io_in,
	output logic            rb_n
);
	logic        we_q = 1, rstb_q = 1, stat_q = 0, mread_q = 0, wp_bad = 0;
	logic [2:0]  acnt = 0;
	logic [11:0] col = 0;
	logic [16:0] row = 0, page = 0;
	logic [7:0]  cmd = 8'h00, status = 8'hc0, dout = 8'h00; // Read latched at power-on
	int          busy = 0, nprog = 0, n85 = 0;
	logic        wr_edge;

	// Released bus shows inverted data so a stale byte never passes
	assign io_in   = pins.read_strobe_n ? ~dout : dout;
	assign rb_n    = (busy == 0);
	assign wr_edge = pins.we_n && !we_q && !pins.ce_n;
	// Strobe edges are seen on the system clock
	always @(posedge clk) begin
		we_q <= pins.we_n;
		rstb_q <= pins.read_strobe_n;
		if (busy > 0)
			busy <= busy - 1;
		if (wr_edge && pins.cle) begin
			cmd <= pins.io;
			acnt <= (pins.io == 8'h60) ? 3'h2 : 3'h0;
			stat_q <= (pins.io == 8'h70);
			mread_q <= (pins.io == 8'h60);
			case (pins.io)
			8'h30: begin
				page <= row;
				busy <= BUSY_CYC;
				wp_bad <= wp_bad | (mread_q & ~pins.wp_n);
			end
			8'h31, 8'h3f: begin
				page <= page + 17'h1;
				col <= 12'h0;
				busy <= BUSY_CYC;
			end
			8'h10: begin
				status <= {7'h60, fail_in};
				busy <= BUSY_CYC;
			end
			8'h11, 8'hff: busy <= BUSY_CYC;
			8'h80: nprog <= 0;
			8'h85: n85 <= n85 + 1;
			default: ;
			endcase
		end else if (wr_edge && pins.ale) begin
			acnt <= acnt + 3'h1;
			case (acnt)
			3'h0: col[7:0] <= pins.io;
			3'h1: col[11:8] <= pins.io[3:0];
			3'h2: row[7:0] <= pins.io;
			3'h3: row[15:8] <= pins.io;
			default: row[16] <= pins.io[0];
			endcase
		end else if (wr_edge && pins.oe) begin
			nprog <= nprog + 1;
			col <= col + 12'h1;
		end
		if (!pins.read_strobe_n && rstb_q && !pins.ce_n) begin
			dout <= stat_q ? status : page[7:0] + col[7:0];
			if (!stat_q)
				col <= col + 12'h1;
		end
	end
endmodule // nrps_flash_model

// *** verif/nrps_top_bench.sv ***
// Self-checking bench for the flash command sequencer
`timescale 1ns/100ps
module nrps_top_bench
	import nrps_pkg::*;
;
	logic       CLK = 0, SRST = 1, REQ_VALID = 0, WR_VALID = 0, PROTECT = 0, fail_in = 0;
	logic       REQ_READY, DONE, ERR, WR_READY, RD_VALID, STAT_FAIL, RB_N, err_q;
	logic [7:0] WR_DATA = 8'h00, RD_DATA, IO_IN, rdq[$];
	nrps_req_s  REQ = '0;
	nrps_pins_s PINS;
	int         miscompares = 0, comparisons = 0, cycles = 0;

	nrps_top u_nrps_top (.CLK(CLK), .SRST(SRST), .REQ_VALID(REQ_VALID), .REQ(REQ),
		.REQ_READY(REQ_READY), .DONE(DONE), .ERR(ERR), .WR_VALID(WR_VALID),
		.WR_DATA(WR_DATA), .WR_READY(WR_READY), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA),
		.STAT_FAIL(STAT_FAIL), .PROTECT(PROTECT), .IO_IN(IO_IN), .RB_N(RB_N), .PINS(PINS));
	nrps_flash_model u_nrps_flash_model (.clk(CLK), .pins(PINS), .fail_in(fail_in),
		.io_in(IO_IN), .rb_n(RB_N));

	// Clock; ceiling is far above the seven hundred or so cycles the run needs
	always #10 CLK = ~CLK;
	always @(posedge CLK) begin
		cycles++;
		if (RD_VALID === 1'b1)
			rdq.push_back(RD_DATA);
		if (cycles == 60000) begin
			miscompares++;
			test_done();
		end
	end

	task automatic test_done;
		if (miscompares == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	// Offer one request, wait for its end, keep the refusal flag
	task automatic run(input nrps_req_s r);
		int n;
		rdq.delete();
		REQ = r;
		REQ_VALID = 1;
		@(posedge CLK);
		#1 REQ_VALID = 0;
		for (n = 0; n < 20000 && DONE !== 1'b1; n++) begin
			@(posedge CLK);
			#1;
		end
		err_q = ERR;
		@(posedge CLK);
		#1;
	endtask

	task automatic op(input nrps_op_e o, input logic [16:0] r, input logic [16:0] r2);
		run('{o, 12'h0, r, r2, 12'h0, 12'h2, 12'h0});
	endtask

	task automatic rdchk(input logic [7:0] base, input int n);
		check(rdq.size(), n);
		for (int i = 0; i < n; i++)
			check(rdq[i], base + 8'(i));
	endtask

	// Hold valid across bytes so it never toggles within one step
	task automatic fill(input int n);
		WR_VALID = 1;
		for (int i = 0; i < n; i++) begin
			WR_DATA = 8'ha0 + 8'(i);
			do @(posedge CLK); while (WR_READY !== 1'b1);
			#1;
		end
		WR_VALID = 0;
	endtask

	task automatic t_read;
		run('{NRPS_OP_READ, 12'h005, 17'h000c2, 17'h0, 12'h0, 12'h3, 12'h0});
		check(u_nrps_flash_model.cmd, 8'h30);
		check(err_q, 0);
		rdchk(8'hc7, 3);
		run('{NRPS_OP_READ_COL, 12'h7f0, 17'h0, 17'h0, 12'h0, 12'h2, 12'h0});
		rdchk(8'hb2, 2);
	endtask

	// Two cached pages, the last page, then a refused follow-on
	task automatic t_cache;
		for (int k = 0; k < 3; k++) begin
			op(k < 2 ? NRPS_OP_CNEXT : NRPS_OP_CLAST, 17'h0, 17'h0);
			rdchk(8'hc3 + 8'(k), 2);
		end
		op(NRPS_OP_CNEXT, 17'h0, 17'h0);
		check(err_q, 1);
	endtask

	task automatic t_mread;
		PROTECT = 1;
		op(NRPS_OP_MREAD, 17'h00045, 17'h00005);
		check(err_q, 0);
		check(u_nrps_flash_model.wp_bad, 0);
		check(PINS.wp_n, 0);
		op(NRPS_OP_MREAD, 17'h00046, 17'h00005);
		check(err_q, 1);
		op(NRPS_OP_MREAD, 17'h00085, 17'h00005);
		check(err_q, 1);
		PROTECT = 0;
	endtask

	// Fill the buffer to refusal, program with a column change
	task automatic t_prog;
		fill(8);
		check(WR_READY, 0);
		run('{NRPS_OP_PROG, 12'h0, 17'h00100, 17'h0, 12'h040, 12'h4, 12'h4});
		check(u_nrps_flash_model.nprog, 8);
		check(u_nrps_flash_model.n85, 1);
		check(u_nrps_flash_model.col, 12'h044);
		check(WR_READY, 1);
		check(STAT_FAIL, 0);
		fill(2);
		run('{NRPS_OP_PROG, 12'h0, 17'h00140, 17'h0, 12'h0, 12'h2, 12'h0});
		check(u_nrps_flash_model.nprog, 2);
		check(u_nrps_flash_model.n85, 1);
		fill(2);
		fail_in = 1;
		run('{NRPS_OP_MPROG, 12'h0, 17'h00042, 17'h00002, 12'h0, 12'h1, 12'h0});
		check(err_q, 0);
		check(u_nrps_flash_model.nprog, 2);
		check(STAT_FAIL, 1);
		fail_in = 0;
		op(NRPS_OP_STATUS, 17'h0, 17'h0);
		rdchk(8'hc1, 1);
		op(NRPS_OP_RESET, 17'h0, 17'h0);
		check(u_nrps_flash_model.cmd, 8'hff);
		check(RB_N, 1);
	endtask

	// Reset, then every scenario in turn
	initial begin
		repeat (4) @(posedge CLK);
		#1 SRST = 0;
		check(PINS.ce_n & PINS.we_n & PINS.read_strobe_n, 1);
		check(REQ_READY, 1);
		t_read;
		t_cache;
		t_mread;
		t_prog;
		test_done();
	end
endmodule // nrps_top_bench
